// [testbench/reset_cause_recorder_bench.sv]
// self-checking bench of the reset cause recorder
`timescale 1ns/1ps
module reset_cause_recorder_bench;
  logic mclk_i, rst_i, cyc_i, stb_i, we_i, last_err;
  logic [4:0] adr_i, fire, req;
  logic [3:0] sel_i;
  logic [31:0] dat_i, q, d;
  wire [31:0] dat_o;
  wire ack_o, err_o, system_reset_o, boot_done_o, irq_o;
  int errors, checks_done, seed, flags, st, mask, k;
  int pend[$];
  reset_sources i_src (.mclk_i(mclk_i), .fire_i(fire), .req_o(req));
  reset_cause_recorder #(.BOOT_CYCLES(16)) i_dut (.mclk_i(mclk_i),
    .rst_i(rst_i), .power_on_req_i(req[0]), .undervoltage_req_i(req[1]),
    .pin_req_i(req[2]), .watchdog_req_i(req[3]),
    .debug_port_req_i(req[4]), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .system_reset_o(system_reset_o), .boot_done_o(boot_done_o),
    .irq_o(irq_o));
  // ******
  // tasks
  // ******
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input int v);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do
      @(posedge mclk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    last_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [4:0] a, input int e, input string nm);
    bus(1'b0, a, 0);
    chk(nm, q, e);
  endtask
  task automatic cause(input int i);
    pend.push_back(i);
    fire <= 5'h01 << i;
    @(posedge mclk_i);
    fire <= 5'h00;
    while (system_reset_o !== 1'b1)
      @(posedge mclk_i);
    // one spare edge so a following cause never re-drives fire at once
    @(posedge mclk_i);
  endtask
  task automatic wait_boot;
    while (boot_done_o !== 1'b1)
      @(posedge mclk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ******
  // tests
  // ******
  initial
  begin
    #200000;
    errors++;
    close_out;
  end
  initial
  begin
    seed = 4004;
    {rst_i, cyc_i, stb_i, we_i, adr_i, fire, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    sel_i = 4'hf;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(5'h0c, 0, "mask");
    cause(0);
    cause(3); // watchdog lands inside the power-on block
    wait_boot;
    rd(5'h00, 1, "flags");
    pend.delete();
    bus(1'b1, 5'h00, 63);
    bus(1'b1, 5'h08, 63);
    bus(1'b1, 5'h0c, 63);
    mask = 63;
    rd(5'h00, 0, "flags");
    for (int i = 1; i < 5; i++)
    begin
      cause(i);
      wait_boot;
      while (pend.size() > 0)
      begin
        k = pend.pop_front();
        flags |= (k == 4) ? 32 : (1 << k);
      end
      st = flags;
      rd(5'h00, flags, "flags");
      chk("irq", irq_o, 1);
      $display("test cause %0d done", i);
    end
    d = $random(seed);
    bus(1'b1, 5'h00, d);
    flags &= ~(d & 32'h3f);
    rd(5'h00, flags, "flags");
    bus(1'b1, 5'h08, d);
    st &= ~(d & 32'h3f);
    chk("irq", irq_o, (st & mask) != 0);
    bus(1'b1, 5'h0c, 0);
    chk("irq", irq_o, 0);
    cause(0);
    wait_boot;
    rd(5'h00, 1, "flags");
    cause(2);
    wait_boot;
    rd(5'h00, 5, "flags");
    bus(1'b1, 5'h00, 1);
    rd(5'h00, 4, "flags");
    $display("test power-on done");
    bus(1'b1, 5'h04, 1);
    wait_boot;
    rd(5'h00, 20, "flags");
    rd(5'h04, 0, "trigger");
    bus(1'b0, 5'h14, 0);
    chk("err", last_err, 1);
    bus(1'b1, 5'h02, 63);
    chk("err", last_err, 1);
    rd(5'h00, 20, "flags");
    $display("test software and bus done");
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("sysrst", system_reset_o, 1);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    wait_boot;
    chk("sysrst", system_reset_o, 0);
    rd(5'h10, 1, "boot");
    rd(5'h00, 20, "flags");
    $display("test mid-run reset done");
    close_out;
  end
endmodule

// [testbench/reset_cause_recorder_properties.sv]
// port assertions of the reset cause recorder
`timescale 1ns/1ps
module reset_cause_recorder_checker
(
  input wire mclk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire system_reset_o,
  input wire boot_done_o
);
  // ******
  // checks
  // ******
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  a_answer_next: assert property (req |=> ack_o || err_o)
    else $error("no answer after request");
  a_err_unmapped: assert property (req && (adr_i[1:0] != 2'h0 ||
    adr_i[4:2] > 3'h4) |=> err_o && !ack_o) else $error("unmapped acked");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data without ack");
  a_flag_top_zero: assert property (ack_o && !we_i &&
    adr_i == 5'h00 |-> dat_o[31:6] == 26'h0) else $error("flag top set");
  a_swr_reads_zero: assert property (ack_o && !we_i &&
    adr_i == 5'h04 |-> dat_o == 32'h0) else $error("trigger reads one");
  a_swr_resets: assert property (ack_o && we_i && sel_i[0] &&
    dat_i[0] && adr_i == 5'h04 |=> system_reset_o)
    else $error("no system reset");
  a_boot_exclusive: assert property (boot_done_o |->
    !system_reset_o) else $error("reset while booted");
endmodule
bind reset_cause_recorder reset_cause_recorder_checker i_chk (.*);

// [testbench/reset_sources.sv]
// reset request sources model: power monitor, watchdog, pin, debug port
`timescale 1ns/1ps
module reset_sources
(
  // clock
  input wire logic mclk_i,
  // one-cycle fire strobes and request lines
  input wire logic [4:0] fire_i,
  output logic [4:0] req_o
);
  // ******
  // hold
  // ******
  // a request is held four cycles so the two-stage sync surely sees it
  logic [2:0] cnt [5] = '{default: 3'h0};
  initial req_o = 5'h00;
  always @(posedge mclk_i)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (fire_i[i])
        cnt[i] <= 3'h4;
      else if (cnt[i] != 3'h0)
        cnt[i] <= cnt[i] - 3'h1;
      req_o[i] <= fire_i[i] || cnt[i] > 3'h1;
    end
  end
endmodule

// [verilog/cause_sync.v]
// two-stage synchroniser bank for asynchronous reset request lines
`timescale 1ns/1ps
module cause_sync
#(
  parameter WIDTH = 6
)
(
  // clock
  input wire mclk_i,
  // asynchronous inputs and synchronised outputs
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  // no reset here: a request must survive the reset it causes
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : stage
      always @(posedge mclk_i)
      begin
        meta_r[g] <= async_i[g];
        stable_r[g] <= meta_r[g];
      end
    end
  endgenerate

  assign sync_o = stable_r;
endmodule

// [verilog/reset_cause_recorder.v]
// reset cause recorder with software reset request and wishbone slave
//
// Function
// - 8-bit cause flag register, bits 7:6 zero
// - writing one clears a flag, zero keeps
// - power-on reset clears all but power-on flag
// - debug port reset sets flag bit 5
// - software reset sets flag bit 4
// - watchdog reset sets flag bit 3
// - pin reset sets flag bit 2
// - undervoltage reset sets flag bit 1
// - power-on sets bit 0, cleared by software only
// - after power-on only power-on flag set
// - other flags blocked until boot completes
// - software reset register, trigger bit 0
`timescale 1ns/1ps
`include "reset_cause_recorder_regs.vh"
module reset_cause_recorder
#(
  parameter BOOT_CYCLES = `BOOT_CYCLES_DEFAULT,
  parameter SW_PULSE_CYCLES = `SW_RESET_PULSE_CYCLES
)
(
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // reset request lines from the sources (asynchronous)
  input wire power_on_req_i,
  input wire undervoltage_req_i,
  input wire pin_req_i,
  input wire watchdog_req_i,
  input wire debug_port_req_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  output wire err_o,
  // system side
  output wire system_reset_o,
  output wire boot_done_o,
  output wire irq_o
);

  // ******************************************************
  // functions
  // ******************************************************
  // word index of the bus address, valid only for aligned words
  function [2:0] reg_index;
    input [4:0] adr;
    begin
      reg_index = adr[4:2];
    end
  endfunction

  function is_mapped;
    input [4:0] adr;
    begin
      is_mapped = (adr[1:0] == 2'h0) &&
                  (adr[4:2] <= `IDX_BOOT_STATUS);
    end
  endfunction

  // ******************************************************
  // synchronise the request lines
  // ******************************************************
  wire [`NUM_CAUSES-1:0] req_async;
  wire [`NUM_CAUSES-1:0] req_sync;
  reg sw_req_r;

  // software requests are already synchronous; the slot is tied low
  assign req_async[`BIT_POWER_ON] = power_on_req_i;
  assign req_async[`BIT_UNDERVOLTAGE] = undervoltage_req_i;
  assign req_async[`BIT_PIN] = pin_req_i;
  assign req_async[`BIT_WATCHDOG] = watchdog_req_i;
  assign req_async[`BIT_SOFTWARE] = 1'b0;
  assign req_async[`BIT_DEBUG_PORT] = debug_port_req_i;

  cause_sync
  #(
    .WIDTH(`NUM_CAUSES)
  )
  u_sync
  (
    .mclk_i(mclk_i),
    .async_i(req_async),
    .sync_o(req_sync)
  );

  reg [`NUM_CAUSES-1:0] req_d_r;
  wire [`NUM_CAUSES-1:0] req_now;
  wire [`NUM_CAUSES-1:0] req_rise;

  assign req_now = {req_sync[`NUM_CAUSES-1:`BIT_SOFTWARE+1], sw_req_r,
                    req_sync[`BIT_SOFTWARE-1:0]};
  assign req_rise = req_now & ~req_d_r;

  // ******************************************************
  // bus decode
  // ******************************************************
  reg ack_r;
  reg err_r;
  reg [31:0] dat_r;
  wire bus_req;
  wire wr_ok;
  wire lane0;
  wire [2:0] idx;
  wire [7:0] wbyte;

  assign bus_req = cyc_i && stb_i && !ack_r && !err_r;
  assign idx = reg_index(adr_i);
  assign lane0 = sel_i[0];
  assign wbyte = dat_i[7:0];
  assign wr_ok = bus_req && we_i && is_mapped(adr_i) && lane0;

  wire wr_flags;
  wire wr_swr;
  wire wr_istat;
  wire wr_imask;
  assign wr_flags = wr_ok && (idx == `IDX_CAUSE_FLAGS);
  assign wr_swr = wr_ok && (idx == `IDX_SW_RESET);
  assign wr_istat = wr_ok && (idx == `IDX_IRQ_STATUS);
  assign wr_imask = wr_ok && (idx == `IDX_IRQ_MASK);

  // ******************************************************
  // boot sequencer
  // ******************************************************
  localparam ST_BOOT = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_SWRST = 3'b100;

  // counter wide enough for any sensible boot length; the last values
  // are cut to the counter width on purpose
  localparam CW = 16;
  localparam integer BOOT_LAST_I = BOOT_CYCLES - 1;
  localparam integer PULSE_LAST_I = SW_PULSE_CYCLES - 1;
  localparam [CW-1:0] BOOT_LAST = BOOT_LAST_I[CW-1:0];
  localparam [CW-1:0] PULSE_LAST = PULSE_LAST_I[CW-1:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg sysrst_r;
  reg boot_done_r;
  reg por_block_r;
  wire any_reset;

  // any source reset, including one raised by software
  assign any_reset = |req_rise;

  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_BOOT:
      begin
        if (any_reset)
          cnt_nxt = {CW{1'b0}};
        else if (cnt_r == BOOT_LAST)
          state_nxt = ST_RUN;
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      ST_RUN:
      begin
        cnt_nxt = {CW{1'b0}};
        if (wr_swr && wbyte[`BIT_SW_TRIGGER])
          state_nxt = ST_SWRST;
        else if (any_reset)
          state_nxt = ST_BOOT;
      end
      ST_SWRST:
      begin
        if (cnt_r == PULSE_LAST)
        begin
          state_nxt = ST_BOOT;
          cnt_nxt = {CW{1'b0}};
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      default:
      begin
        state_nxt = ST_BOOT;
        cnt_nxt = {CW{1'b0}};
      end
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_BOOT;
      cnt_r <= {CW{1'b0}};
      req_d_r <= `CAUSE_NONE;
      sw_req_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      req_d_r <= req_now;
      // one-cycle software request as the system reset begins
      sw_req_r <= (state_r == ST_RUN) && (state_nxt == ST_SWRST);
    end
  end

  // system reset held during boot and the software pulse
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sysrst_r <= 1'b1;
      boot_done_r <= 1'b0;
    end
    else
    begin
      sysrst_r <= (state_nxt != ST_RUN);
      boot_done_r <= (state_nxt == ST_RUN);
    end
  end

  // ******************************************************
  // cause flags
  // ******************************************************
  reg [`NUM_CAUSES-1:0] flags_r;
  reg [`NUM_CAUSES-1:0] flags_nxt;
  reg [`NUM_CAUSES-1:0] clr;
  reg [`NUM_CAUSES-1:0] set;

  always @*
  begin
    clr = wr_flags ? wbyte[`NUM_CAUSES-1:0] : `CAUSE_NONE;
    set = req_rise;
    // hold off the other causes until boot after power-on ends
    if (por_block_r)
      set = set & `CAUSE_ONLY_POR;
    flags_nxt = flags_r & ~clr;
    if (req_rise[`BIT_POWER_ON])
      flags_nxt = `CAUSE_ONLY_POR;
    else
      flags_nxt = flags_nxt | set;
  end

  // flags survive rst_i: only a power-on event or software clears them;
  // the power-up value is undefined, as a real cause register would be
  always @(posedge mclk_i)
  begin
    flags_r <= flags_nxt;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      por_block_r <= 1'b1;
    else if (req_rise[`BIT_POWER_ON])
      por_block_r <= 1'b1;
    else if (state_r == ST_RUN)
      por_block_r <= 1'b0;
  end

  // ******************************************************
  // interrupts
  // ******************************************************
  reg [`NUM_CAUSES-1:0] istat_r;
  reg [`NUM_CAUSES-1:0] imask_r;
  reg irq_r;
  wire [`NUM_CAUSES-1:0] iclr;

  assign iclr = wr_istat ? wbyte[`NUM_CAUSES-1:0] : `CAUSE_NONE;

  // a recorded event wins over a clear in the same cycle
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      istat_r <= `CAUSE_NONE;
      imask_r <= `MASK_RESET;
      irq_r <= 1'b0;
    end
    else
    begin
      istat_r <= (istat_r & ~iclr) | (flags_nxt & ~flags_r);
      if (wr_imask)
        imask_r <= wbyte[`NUM_CAUSES-1:0];
      irq_r <= |(((istat_r & ~iclr) | (flags_nxt & ~flags_r)) &
                 (wr_imask ? wbyte[`NUM_CAUSES-1:0] : imask_r));
    end
  end

  // ******************************************************
  // read data and acknowledge
  // ******************************************************
  reg [7:0] rbyte;

  always @*
  begin
    case (idx)
      `IDX_CAUSE_FLAGS: rbyte = {2'h0, flags_r};
      `IDX_SW_RESET: rbyte = `BYTE_ZERO;
      `IDX_IRQ_STATUS: rbyte = {2'h0, istat_r};
      `IDX_IRQ_MASK: rbyte = {2'h0, imask_r};
      `IDX_BOOT_STATUS: rbyte = {7'h00, boot_done_r};
      default: rbyte = `BYTE_ZERO;
    endcase
  end

  // one wait-free answer in the cycle after the request is seen
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= `WORD_ZERO;
    end
    else
    begin
      ack_r <= bus_req && is_mapped(adr_i);
      err_r <= bus_req && !is_mapped(adr_i);
      if (bus_req && !we_i && is_mapped(adr_i))
        dat_r <= {24'h000000, rbyte};
      else
        dat_r <= `WORD_ZERO;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign err_o = err_r;
  assign system_reset_o = sysrst_r;
  assign boot_done_o = boot_done_r;
  assign irq_o = irq_r;
endmodule

// [verilog/reset_cause_recorder_regs.vh]
// register map, field positions and constants of the reset cause recorder
`ifndef RESET_CAUSE_RECORDER_REGS_VH
`define RESET_CAUSE_RECORDER_REGS_VH

// ******************************************************
// register indices (byte address is four times index)
// ******************************************************
`define IDX_CAUSE_FLAGS 3'h0
`define IDX_SW_RESET 3'h1
`define IDX_IRQ_STATUS 3'h2
`define IDX_IRQ_MASK 3'h3
`define IDX_BOOT_STATUS 3'h4

// ******************************************************
// field positions of the cause flag register
// ******************************************************
`define BIT_POWER_ON 0
`define BIT_UNDERVOLTAGE 1
`define BIT_PIN 2
`define BIT_WATCHDOG 3
`define BIT_SOFTWARE 4
`define BIT_DEBUG_PORT 5
`define NUM_CAUSES 6
`define CAUSE_ALL_ONES 6'h3f
`define CAUSE_ONLY_POR 6'h01
`define CAUSE_NONE 6'h00
`define BIT_SW_TRIGGER 0

// ******************************************************
// reset values and timing
// ******************************************************
`define MASK_RESET 6'h00
`define BOOT_CYCLES_DEFAULT 16
`define SW_RESET_PULSE_CYCLES 4
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000

`endif
